// ---- hw/lbc_cfg.svh ----
`ifndef LBC_CFG_SVH
`define LBC_CFG_SVH
// ==========================================
// widths and field positions
`define LBC_DATA_W      8
`define LBC_ADDR_W      7
`define LBC_PC_W        11
`define LBC_PCH_MSB     10
`define LBC_PCH_LSB     8
`define LBC_TABLE_HIGH_POINTER_MSB    2
`define LBC_SP_W        4
`define LBC_STACK_DEPTH 16
`define LBC_ZERO_BIT    2
// ==========================================
// reset values and step sizes
`define LBC_ACC_RST     8'h00
`define LBC_PC_RST      11'h000
`define LBC_SP_RST      4'h0
`define LBC_TABLE_HIGH_POINTER_RST    8'h00
`define LBC_STATUS_RST  8'h00
`define LBC_PC_STEP     11'h001
`define LBC_SP_STEP     4'h1
`endif

// ---- hw/lbc_pkg.sv ----
`include "lbc_cfg.svh"
package lbc_pkg;
	typedef enum logic [2:0]
	{
		LBC_OP_AND_REG  = 3'h0,
		LBC_OP_AND_IMM  = 3'h1,
		LBC_OP_BIT_CLR  = 3'h2,
		LBC_OP_BIT_SET  = 3'h3,
		LBC_OP_BIT_TSC  = 3'h4,
		LBC_OP_CALL_ACC = 3'h5,
		LBC_OP_NOP      = 3'h6
	} lbc_op_e;

	typedef enum logic [2:0]
	{
		LBC_ST_EXEC   = 3'b001,
		LBC_ST_SKIP   = 3'b010,
		LBC_ST_CALL2  = 3'b100
	} lbc_state_e;

	typedef struct packed
	{
		lbc_op_e                     op;
		logic [`LBC_ADDR_W-1:0]      addr;
		logic                        destReg;
		logic [2:0]                  bitSel;
		logic [`LBC_DATA_W-1:0]      imm;
	} lbc_instr_s;

	typedef struct packed
	{
		logic                        we;
		logic [`LBC_ADDR_W-1:0]      addr;
		logic [`LBC_DATA_W-1:0]      data;
	} lbc_fwr_s;

	typedef struct packed
	{
		lbc_state_e                  state;
		logic [`LBC_DATA_W-1:0]      acc;
		logic                        zero;
		logic [`LBC_PC_W-1:0]        pc;
		logic [`LBC_SP_W-1:0]        sp;
		lbc_fwr_s                    fwr;
		logic                        push;
		logic [`LBC_PC_W-1:0]        pushData;
	} lbc_state_s;
endpackage

// ---- hw/lbc_return_stack.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "lbc_cfg.svh"
// ==========================================
// return address stack, written at the pointer
module lbc_return_stack #(
	parameter int DEPTH = `LBC_STACK_DEPTH,
	parameter int SP_W  = `LBC_SP_W,
	parameter int PC_W  = `LBC_PC_W
) (
	input  wire logic            sys_clk,
	input  wire logic            push,
	input  wire logic [SP_W-1:0] wrPtr,
	input  wire logic [PC_W-1:0] wrData,
	input  wire logic [SP_W-1:0] rdPtr,
	output logic      [PC_W-1:0] rdData
);
	logic [PC_W-1:0] mem [DEPTH];

	always_ff @(posedge sys_clk)
	begin
		if (push)
			mem[wrPtr] <= wrData;
		rdData <= mem[rdPtr];
	end
endmodule // lbc_return_stack
`default_nettype wire

// ---- hw/lbc_exec.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "lbc_cfg.svh"
// Contract
// - and_acc_reg ands accumulator with file register
// - destination bit 0 accumulator, 1 register
// - and_acc_imm ands accumulator with immediate
// - bit_clear_reg zeros one bit, flags kept
// - bit_set_reg sets one bit, flags kept
// - clear tested bit discards prefetched instruction
// - test takes one cycle, two if skipping
// - call pushes pc plus one, advances pointer
// - call loads pc from table_high_pointer, accumulator
module lbc_exec (
	input  wire logic                   sys_clk,
	input  wire logic                   reset,
	input  wire lbc_pkg::lbc_instr_s    instr,
	input  wire logic                   instrValid,
	input  wire logic [`LBC_DATA_W-1:0] fileRdData,
	input  wire logic [`LBC_DATA_W-1:0] tableHighPointer,
	output logic      [`LBC_ADDR_W-1:0] fileRdAddr,
	output lbc_pkg::lbc_fwr_s           fileWr,
	output logic                        ready,
	output logic      [`LBC_DATA_W-1:0] accumulator,
	output logic                        zeroFlag,
	output logic      [`LBC_PC_W-1:0]   programCounter,
	output logic      [`LBC_SP_W-1:0]   stackPointer,
	output logic      [`LBC_PC_W-1:0]   stackTop
);
	lbc_pkg::lbc_state_s st_reg;
	lbc_pkg::lbc_state_s st_next;

	// ==========================================
	// helpers
	function automatic logic [`LBC_DATA_W-1:0] bitMask(input logic [2:0] pos);
		bitMask = `LBC_DATA_W'(1) << pos;
	endfunction

	function automatic logic isZero(input logic [`LBC_DATA_W-1:0] v);
		isZero = (v == 8'h00);
	endfunction

	// ==========================================
	// operand read is combinational so every op except call and a skipping test finishes in one cycle
	assign fileRdAddr = instr.addr;

	logic [`LBC_DATA_W-1:0] andReg;
	logic [`LBC_DATA_W-1:0] andImm;
	assign andReg = st_reg.acc & fileRdData;
	assign andImm = st_reg.acc & instr.imm;

	// ==========================================
	// next state
	always_comb
	begin
		st_next = st_reg;
		st_next.fwr.we = 1'b0;
		st_next.push = 1'b0;
		case (st_reg.state)
			lbc_pkg::LBC_ST_EXEC:
			begin
				if (instrValid)
				begin
					st_next.pc = st_reg.pc + `LBC_PC_STEP;
					case (instr.op)
						lbc_pkg::LBC_OP_AND_REG:
						begin
							st_next.zero = isZero(andReg);
							if (instr.destReg)
							begin
								st_next.fwr.we = 1'b1;
								st_next.fwr.addr = instr.addr;
								st_next.fwr.data = andReg;
							end
							else
								st_next.acc = andReg;
						end
						lbc_pkg::LBC_OP_AND_IMM:
						begin
							st_next.acc = andImm;
							st_next.zero = isZero(andImm);
						end
						lbc_pkg::LBC_OP_BIT_CLR, lbc_pkg::LBC_OP_BIT_SET:
						begin
							st_next.fwr.we = 1'b1;
							st_next.fwr.addr = instr.addr;
							if (instr.op == lbc_pkg::LBC_OP_BIT_SET)
								st_next.fwr.data = fileRdData | bitMask(instr.bitSel);
							else
								st_next.fwr.data = fileRdData & ~bitMask(instr.bitSel);
						end
						lbc_pkg::LBC_OP_BIT_TSC:
						begin
							// flags untouched; skip costs the extra cycle
							if ((fileRdData & bitMask(instr.bitSel)) == 8'h00)
								st_next.state = lbc_pkg::LBC_ST_SKIP;
						end
						lbc_pkg::LBC_OP_CALL_ACC:
						begin
							st_next.push = 1'b1;
							st_next.pushData = st_reg.pc + `LBC_PC_STEP;
							st_next.pc = {tableHighPointer[`LBC_TABLE_HIGH_POINTER_MSB:0], st_reg.acc};
							st_next.state = lbc_pkg::LBC_ST_CALL2;
						end
						default:
						begin
						end
					endcase
				end
			end
			lbc_pkg::LBC_ST_SKIP:
			begin
				// prefetched word executes as a nop, pc still steps past it
				if (instrValid)
				begin
					st_next.pc = st_reg.pc + `LBC_PC_STEP;
					st_next.state = lbc_pkg::LBC_ST_EXEC;
				end
			end
			lbc_pkg::LBC_ST_CALL2:
			begin
				st_next.sp = st_reg.sp + `LBC_SP_STEP;
				st_next.state = lbc_pkg::LBC_ST_EXEC;
			end
			default:
				st_next.state = lbc_pkg::LBC_ST_EXEC;
		endcase
	end

	always_ff @(posedge sys_clk)
	begin
		if (reset)
		begin
			st_reg.state    <= lbc_pkg::LBC_ST_EXEC;
			st_reg.acc      <= `LBC_ACC_RST;
			st_reg.zero     <= 1'b0;
			st_reg.pc       <= `LBC_PC_RST;
			st_reg.sp       <= `LBC_SP_RST;
			st_reg.fwr      <= '0;
			st_reg.push     <= 1'b0;
			st_reg.pushData <= `LBC_PC_RST;
		end
		else
			st_reg <= st_next;
	end

	// ==========================================
	// stack storage; written at the pointer before it advances
	lbc_return_stack u_stack (
		.sys_clk (sys_clk),
		.push    (st_reg.push),
		.wrPtr   (st_reg.sp),
		.wrData  (st_reg.pushData),
		.rdPtr   (st_reg.sp - `LBC_SP_STEP),
		.rdData  (stackTop)
	);

	// only the second call cycle holds off the fetch stream; skip does not
	assign ready          = (st_reg.state != lbc_pkg::LBC_ST_CALL2);
	assign fileWr         = st_reg.fwr;
	assign accumulator    = st_reg.acc;
	assign zeroFlag       = st_reg.zero;
	assign programCounter = st_reg.pc;
	assign stackPointer   = st_reg.sp;
endmodule // lbc_exec
`default_nettype wire

// ---- verif/lbc_exec_assertions.sv ----
`timescale 1ns/100ps
`default_nettype none
// ==========
// exec port checks
module lbc_exec_assertions (
	input wire logic	sys_clk,
	input wire logic	reset,
	input wire lbc_pkg::lbc_instr_s	instr,
	input wire logic	instrValid,
	input wire logic [7:0]	fileRdData,
	input wire logic [7:0]	tableHighPointer,
	input wire lbc_pkg::lbc_fwr_s	fileWr,
	input wire logic	ready,
	input wire logic [7:0]	accumulator,
	input wire logic	zeroFlag,
	input wire logic [10:0]	programCounter,
	input wire logic [3:0]	stackPointer,
	input wire logic [10:0]	stackTop
);
	lbc_pkg::lbc_op_e o;
	logic             skipPend;
	// the word taken after a skipping test runs as a nop, so it must not trip the op checks
	always_ff @(posedge sys_clk)
	begin
		if (reset)
			skipPend <= 1'b0;
		else if (instrValid && ready)
			skipPend <= !skipPend && instr.op == lbc_pkg::LBC_OP_BIT_TSC &&
				!fileRdData[instr.bitSel];
	end
	// untaken cycles read as nop so no antecedent fires on them
	assign o = instrValid && ready && !skipPend ? instr.op : lbc_pkg::LBC_OP_NOP;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (reset);
	property p_and; o == lbc_pkg::LBC_OP_AND_REG && instr.destReg |=> fileWr.we &&
		fileWr.data == ($past(accumulator) & $past(fileRdData)); endproperty
	a_and: assert property (p_and) else $error("and");
	property p_imm; o == lbc_pkg::LBC_OP_AND_IMM
		|=> accumulator == ($past(accumulator) & $past(instr.imm)); endproperty
	a_imm: assert property (p_imm) else $error("imm");
	property p_zero; o <= lbc_pkg::LBC_OP_AND_IMM
		|=> zeroFlag == ((fileWr.we ? fileWr.data : accumulator) == 8'h00); endproperty
	a_zero: assert property (p_zero) else $error("zero");
	property p_clr; o == lbc_pkg::LBC_OP_BIT_CLR |=> $stable(zeroFlag) &&
		fileWr.data == ($past(fileRdData) & ~(8'h01 << $past(instr.bitSel))); endproperty
	a_clr: assert property (p_clr) else $error("clr");
	property p_set; o == lbc_pkg::LBC_OP_BIT_SET
		|=> fileWr.data == ($past(fileRdData) | (8'h01 << $past(instr.bitSel))); endproperty
	a_set: assert property (p_set) else $error("set");
	property p_skip; skipPend && instrValid && ready |=> !fileWr.we && $stable(zeroFlag) &&
		$stable(accumulator) && programCounter == $past(programCounter) + 11'h001; endproperty
	a_skip: assert property (p_skip) else $error("skip");
	property p_keep; o == lbc_pkg::LBC_OP_BIT_TSC && fileRdData[instr.bitSel] |=> !fileWr.we &&
		$stable(zeroFlag) && programCounter == $past(programCounter) + 11'h001; endproperty
	a_keep: assert property (p_keep) else $error("keep");
	property p_and_acc; o == lbc_pkg::LBC_OP_AND_REG && !instr.destReg |=> !fileWr.we &&
		accumulator == ($past(accumulator) & $past(fileRdData)); endproperty
	a_and_acc: assert property (p_and_acc) else $error("and acc");
	property p_call; o == lbc_pkg::LBC_OP_CALL_ACC |=> !ready &&
		programCounter == {$past(tableHighPointer[2:0]), $past(accumulator)}; endproperty
	a_call: assert property (p_call) else $error("call");
	property p_push; o == lbc_pkg::LBC_OP_CALL_ACC |=> ##1 stackPointer == $past(stackPointer, 2)
		+ 4'h1 ##1 stackTop == $past(programCounter, 3) + 11'h001; endproperty
	a_push: assert property (p_push) else $error("push");
endmodule // lbc_exec_assertions
bind lbc_exec lbc_exec_assertions chk (
	.sys_clk          (sys_clk),
	.reset            (reset),
	.instr            (instr),
	.instrValid       (instrValid),
	.fileRdData       (fileRdData),
	.tableHighPointer (tableHighPointer),
	.fileWr           (fileWr),
	.ready            (ready),
	.accumulator      (accumulator),
	.zeroFlag         (zeroFlag),
	.programCounter   (programCounter),
	.stackPointer     (stackPointer),
	.stackTop         (stackTop)
);
`default_nettype wire

// ---- verif/tb_top.sv ----
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	logic sys_clk = 1'b0, reset = 1'b1, instrValid = 1'b0, ready, zeroFlag;
	logic [7:0] fileRdData, accumulator, tableHighPointer = 8'hFA;
	logic [6:0] fileRdAddr;
	logic [10:0] programCounter, stackTop;
	logic [3:0] stackPointer;
	lbc_pkg::lbc_instr_s instr = '0;
	lbc_pkg::lbc_fwr_s fileWr;
	int failCount = 0, totalChecks = 0, cycles = 0;
	// ==========
	// register file stand-in, writes are dropped
	assign fileRdData = {1'b0, fileRdAddr} ^ 8'h5A;
	lbc_exec dut (
		.sys_clk          (sys_clk),
		.reset            (reset),
		.instr            (instr),
		.instrValid       (instrValid),
		.fileRdData       (fileRdData),
		.tableHighPointer (tableHighPointer),
		.fileRdAddr       (fileRdAddr),
		.fileWr           (fileWr),
		.ready            (ready),
		.accumulator      (accumulator),
		.zeroFlag         (zeroFlag),
		.programCounter   (programCounter),
		.stackPointer     (stackPointer),
		.stackTop         (stackTop)
	);
	initial forever #4 sys_clk = ~sys_clk;
	always @(posedge sys_clk)
		if (++cycles > 400)
			reportAndStop(1);
	task automatic reportAndStop(input int bad);
		failCount += bad;
		if (failCount == 0 && totalChecks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, exp);
		totalChecks++;
		failCount += int'(got !== exp);
		if (got !== exp)
			$display("unexpected %0t %h %h", $time, got, exp);
	endtask
	task automatic go(input lbc_pkg::lbc_op_e op, logic [6:0] a, logic [2:0] b,
		logic d = 1'b1);
		@(posedge sys_clk);
		instr <= '{op, a, d, b, 8'hAF};
		instrValid <= 1'b1;
	endtask
	task automatic idle();
		@(posedge sys_clk);
		instrValid <= 1'b0;
		#1;
	endtask
	task automatic tAnd();
		go(lbc_pkg::LBC_OP_AND_IMM, 7'h00, 3'h0);
		go(lbc_pkg::LBC_OP_AND_REG, 7'h7F, 3'h0);
		idle();
		chk(fileWr, {1'b1, 7'h7F, 8'h00});
		chk(zeroFlag, 1'b1);
		go(lbc_pkg::LBC_OP_AND_REG, 7'h7F, 3'h0, 1'b0);
		idle();
		chk(fileWr.we, 1'b0);
		chk(accumulator, 8'h00);
		chk(zeroFlag, 1'b1);
	endtask
	// stand-in reads 8'h5F at address 5; each op is judged before the next
	task automatic tBits();
		logic [7:0] m;
		for (int b = 0; b < 16; b++)
		begin
			m = 8'h01 << b[2:0];
			go(b[3] ? lbc_pkg::LBC_OP_BIT_SET : lbc_pkg::LBC_OP_BIT_CLR, 7'h05, b[2:0]);
			idle();
			chk(fileWr, {1'b1, 7'h05, b[3] ? (8'h5F | m) : (8'h5F & ~m)});
		end
		chk(zeroFlag, 1'b1);
	endtask
	task automatic tSkip();
		logic [10:0] pc0;
		pc0 = programCounter;
		go(lbc_pkg::LBC_OP_BIT_TSC, 7'h05, 3'h0);
		go(lbc_pkg::LBC_OP_BIT_SET, 7'h05, 3'h7);
		idle();
		chk(fileWr, {1'b1, 7'h05, 8'hDF});
		chk(programCounter, pc0 + 11'h002);
		go(lbc_pkg::LBC_OP_BIT_TSC, 7'h05, 3'h5);
		go(lbc_pkg::LBC_OP_BIT_SET, 7'h05, 3'h7);
		idle();
		chk(fileWr.we, 1'b0);
		chk(programCounter, pc0 + 11'h004);
		chk(zeroFlag, 1'b1);
	endtask
	// accumulator stays at its reset value, only the ands reach it
	task automatic tCall();
		logic [10:0] pc0;
		pc0 = programCounter;
		go(lbc_pkg::LBC_OP_CALL_ACC, 7'h00, 3'h0);
		idle();
		chk(ready, 1'b0);
		chk(programCounter, 11'h200);
		@(posedge sys_clk);
		#1;
		chk(stackPointer, 4'h1);
		@(posedge sys_clk);
		#1;
		chk(stackTop, pc0 + 11'h001);
	endtask
	initial
	begin
		repeat (4) @(posedge sys_clk);
		reset <= 1'b0;
		tAnd();
		tBits();
		tSkip();
		tCall();
		reportAndStop(0);
	end
endmodule // tb_top
`default_nettype wire
